/* shared/ccmd_pkg.sv */
// package: command codes, settings layout and constants for the common command handler
package ccmd_pkg;

  localparam int          SET_W        = 32;
  localparam int          SLOT_N       = 5;
  localparam logic [2:0]  SLOT_MIN     = 3'h1;
  localparam logic [2:0]  SLOT_MAX     = 3'h5;
  localparam int          OPC_BIT      = 0;
  localparam logic [7:0]  ASCII_ONE    = 8'h31;
  localparam logic [7:0]  SRE_RESET    = 8'h00;
  localparam logic [7:0]  SRE_SRQ      = 8'h20;
  localparam logic [7:0]  ESR_RESET    = 8'h00;
  localparam logic [SET_W-1:0] SET_DEFAULT = 32'h0000_0000;

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_OPC,
    CMD_OPC_Q,
    CMD_RCL,
    CMD_RST,
    CMD_SAV,
    CMD_SRE,
    CMD_SRE_Q,
    CMD_STB_Q,
    CMD_TRG
  } cmd_code_t;

  typedef struct packed {
    cmd_code_t  code;
    logic [7:0] arg;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } resp_t;

endpackage

/* logic/setup_store.sv */
// setup_store: five setup slots, registered read data
`timescale 1ns/1ps
module setup_store
  import ccmd_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [2:0]       addr_i,
  input  wire logic [SET_W-1:0] wr_data_i,
  output logic      [SET_W-1:0] rd_data_o
);

  // contents kept by the nonvolatile array; no reset on purpose
  logic [SET_W-1:0] mem [SLOT_N];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[addr_i];
  end

endmodule

/* logic/common_command_status_handler.sv */
// common_command_status_handler: common command interpreter with status and setups
`timescale 1ns/1ps
module common_command_status_handler
  import ccmd_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire cmd_t             cmd_i,
  input  wire logic             cmd_valid_i,
  input  wire logic             get_i,
  input  wire logic             ovl_busy_i,
  input  wire logic             arm_src_bus_i,
  input  wire logic [7:0]       stb_i,
  input  wire logic             resp_ready_i,
  output logic                  cmd_ready_o,
  output resp_t                 resp_o,
  output logic      [7:0]       esr_o,
  output logic      [7:0]       sre_o,
  output logic      [SET_W-1:0] settings_o,
  input  wire logic [SET_W-1:0] settings_wr_i,
  input  wire logic             settings_wr_en_i,
  output logic                  trig_o,
  output logic                  bad_slot_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin input synchroniser for the busy level (from outside the domain)
  logic busy_s1_r;
  logic busy_s2_r;
  logic busy_s3_r;
  logic busy_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      busy_s3_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      busy_s1_r <= ovl_busy_i;
      busy_s2_r <= busy_s1_r;
      busy_s3_r <= busy_s2_r;
      if (busy_s2_r == busy_s3_r) begin
        busy_r <= busy_s3_r;
      end
    end
  end

  // trigger pin input synchroniser, edge taken only on agreement
  logic get_s1_r;
  logic get_s2_r;
  logic get_s3_r;
  logic get_r;
  logic get_pulse;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      get_s1_r <= 1'b0;
      get_s2_r <= 1'b0;
      get_s3_r <= 1'b0;
      get_r    <= 1'b0;
    end else begin
      get_s1_r <= get_i;
      get_s2_r <= get_s1_r;
      get_s3_r <= get_s2_r;
      if (get_s2_r == get_s3_r) begin
        get_r <= get_s3_r;
      end
    end
  end

  assign get_pulse = (get_s2_r == get_s3_r) && get_s3_r && !get_r;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  logic       take;
  logic       is_rst;
  logic       slot_ok;
  logic       pend_opc_r;
  logic       pend_opcq_r;
  logic       resp_busy;
  logic       hold_off;

  assign resp_busy = resp_o.valid && !resp_ready_i;
  // ready is a register: without this a second command slips in the cycle after the take
  assign hold_off  = take && (cmd_i.code inside {CMD_OPC, CMD_OPC_Q, CMD_SRE_Q, CMD_STB_Q});
  assign take      = cmd_valid_i && cmd_ready_o;
  assign is_rst    = take && (cmd_i.code == CMD_RST);
  assign slot_ok   = (cmd_i.arg[7:3] == 5'h00) && (cmd_i.arg[2:0] >= SLOT_MIN)
                   && (cmd_i.arg[2:0] <= SLOT_MAX);

  // a completion command waits for idle; later commands stall behind it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_ready_o <= 1'b0;
    end else begin
      cmd_ready_o <= !pend_opc_r && !pend_opcq_r && !resp_busy && !hold_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending completion command and query
  logic idle;
  assign idle = !busy_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_opc_r  <= 1'b0;
      pend_opcq_r <= 1'b0;
    end else if (is_rst) begin
      pend_opc_r  <= 1'b0;
      pend_opcq_r <= 1'b0;
    end else begin
      if (take && cmd_i.code == CMD_OPC) begin
        pend_opc_r <= 1'b1;
      end else if (idle) begin
        pend_opc_r <= 1'b0;
      end
      if (take && cmd_i.code == CMD_OPC_Q) begin
        pend_opcq_r <= 1'b1;
      end else if (idle && !resp_busy) begin
        pend_opcq_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standard event status: completion bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      esr_o <= ESR_RESET;
    end else if (pend_opc_r && idle && !is_rst) begin
      esr_o[OPC_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service-request enable, not retained over power-up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sre_o <= SRE_RESET;
    end else if (take && cmd_i.code == CMD_SRE) begin
      sre_o <= cmd_i.arg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output queue word: binary value for enable and status reads (host formats decimal text), ASCII one for completion query
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_o <= '0;
    end else if (is_rst) begin
      resp_o <= '0;
    end else if (resp_busy) begin
      resp_o <= resp_o;
    end else if (pend_opcq_r && idle) begin
      resp_o <= '{valid: 1'b1, data: ASCII_ONE};
    end else if (take && cmd_i.code == CMD_SRE_Q) begin
      resp_o <= '{valid: 1'b1, data: sre_o};
    end else if (take && cmd_i.code == CMD_STB_Q) begin
      resp_o <= '{valid: 1'b1, data: stb_i};
    end else begin
      resp_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger: remote command and bus message merge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_o <= 1'b0;
    end else begin
      trig_o <= arm_src_bus_i
             && (get_pulse || (take && cmd_i.code == CMD_TRG));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings, save and recall
  logic             sav_go;
  logic             rcl_go;
  logic             rcl_wait_r;
  logic             rcl_load_r;
  logic [SET_W-1:0] slot_q;
  logic [2:0]       slot_addr;

  assign sav_go    = take && cmd_i.code == CMD_SAV && slot_ok;
  assign rcl_go    = take && cmd_i.code == CMD_RCL && slot_ok;
  assign slot_addr = cmd_i.arg[2:0] - SLOT_MIN;

  setup_store u_store (
    .clk_i     (clk_i),
    .wr_en_i   (sav_go),
    .addr_i    (slot_addr),
    .wr_data_i (settings_o),
    .rd_data_o (slot_q)
  );

  // recall data comes one cycle later out of the store's register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcl_wait_r <= 1'b0;
      rcl_load_r <= 1'b0;
    end else begin
      rcl_wait_r <= rcl_go;
      rcl_load_r <= rcl_wait_r;
    end
  end

  logic rcl_hit_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcl_hit_r <= 1'b0;
    end else begin
      rcl_hit_r <= rcl_go;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settings_o <= SET_DEFAULT;
    end else if (is_rst) begin
      settings_o <= SET_DEFAULT;
    end else if (rcl_hit_r) begin
      settings_o <= slot_q;
    end else if (settings_wr_en_i) begin
      settings_o <= settings_wr_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bad_slot_o <= 1'b0;
    end else begin
      bad_slot_o <= take && (cmd_i.code == CMD_SAV || cmd_i.code == CMD_RCL) && !slot_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_opc_needs_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(esr_o[OPC_BIT]) |-> $past(idle) && $past(pend_opc_r))
    else $error("completion bit set while busy");
  a_opcq_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pend_opcq_r && idle && !resp_busy && !is_rst |=> resp_o.valid && resp_o.data == ASCII_ONE)
    else $error("completion query did not answer one");
  a_wait_stalls: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pend_opc_r || pend_opcq_r |=> !cmd_ready_o)
    else $error("commands taken while completion pending");
  a_rcl_restore: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rcl_go ##1 !is_rst |=> settings_o == $past(slot_q))
    else $error("recall did not restore slot");
  a_rst_cancel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    is_rst |=> settings_o == SET_DEFAULT && !pend_opc_r && !pend_opcq_r && !resp_o.valid)
    else $error("reset did not cancel");
  a_sre_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take && cmd_i.code == CMD_SRE |=> sre_o == $past(cmd_i.arg))
    else $error("enable write not loaded");
  a_sre_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take && cmd_i.code == CMD_SRE_Q && !pend_opcq_r |=> resp_o.data == $past(sre_o))
    else $error("enable read wrong");
  a_stb_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take && cmd_i.code == CMD_STB_Q |=> resp_o.valid && resp_o.data == $past(stb_i))
    else $error("status byte read wrong");
  a_trg_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    trig_o |-> $past(arm_src_bus_i))
    else $error("trigger while source not bus");
  a_trg_cmd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take && cmd_i.code == CMD_TRG && arm_src_bus_i |=> trig_o)
    else $error("trigger command lost");

  c_opc_done: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(esr_o[OPC_BIT]));
  c_rcl: cover property (@(posedge clk_i) disable iff (!rst_b_i) rcl_load_r);
  c_trig: cover property (@(posedge clk_i) disable iff (!rst_b_i) trig_o);
  c_opcq_wait: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    pend_opcq_r && busy_r ##[1:40] resp_o.valid);

endmodule

/* dv/host_ctrl_model.sv */
// host_ctrl_model: remote controller side that takes responses, able to stall
`timescale 1ns/1ps
module host_ctrl_model
  import ccmd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire resp_t      resp_i,
  input  wire logic       stall_i,
  output logic            ready_o,
  output int              got_o,
  output logic [7:0]      data_o
);
  initial begin
    ready_o = 1'b0;
    got_o   = 0;
    data_o  = 8'h00;
  end
  // ready follows stall one cycle late, like a slow reader
  always @(posedge clk_i) begin
    ready_o <= !stall_i;
    if (resp_i.valid === 1'b1 && ready_o) begin
      got_o  <= got_o + 1;
      data_o <= resp_i.data;
    end
  end
endmodule

/* dv/common_command_status_handler_bench.sv */
// bench: common commands, status reads, setup slots and triggers
`timescale 1ns/1ps
module common_command_status_handler_bench
  import ccmd_pkg::*;
();
  logic             clk, rst_b, cmd_valid, get, busy, arm, stall, set_we;
  logic             cmd_ready, trig, bad_slot, h_ready;
  cmd_t             cmd;
  resp_t            resp;
  logic [7:0]       stb, esr, sre, hdata, d;
  logic [SET_W-1:0] set_wd, settings, s0;
  int               n_fail, total_checks, n_trig, n_bad, got, g0, t0, b0;

  common_command_status_handler i_common_command_status_handler (
    .clk_i(clk), .rst_b_i(rst_b), .cmd_i(cmd), .cmd_valid_i(cmd_valid), .get_i(get),
    .ovl_busy_i(busy), .arm_src_bus_i(arm), .stb_i(stb), .resp_ready_i(h_ready),
    .cmd_ready_o(cmd_ready), .resp_o(resp), .esr_o(esr), .sre_o(sre),
    .settings_o(settings), .settings_wr_i(set_wd), .settings_wr_en_i(set_we),
    .trig_o(trig), .bad_slot_o(bad_slot));
  host_ctrl_model i_host_ctrl_model (
    .clk_i(clk), .resp_i(resp), .stall_i(stall), .ready_o(h_ready), .got_o(got),
    .data_o(hdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulses are one cycle wide, so count them rather than sample them
  always @(posedge clk) begin
    if (trig === 1'b1) n_trig++;
    if (bad_slot === 1'b1) n_bad++;
  end
  //////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task send(input cmd_code_t c, input logic [7:0] a);
    int k;
    @(posedge clk);
    cmd <= '{c, a};
    cmd_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 200);
    cmd_valid <= 1'b0;
    if (k == 200) check("cmd taken", 32'h0, 32'h1);
  endtask
  task ask(input cmd_code_t c, output logic [7:0] v);
    int k;
    g0 = got;
    send(c, 8'h00);
    k = 0;
    while (got == g0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    v = (got != g0) ? hdata : 8'hXX;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    {rst_b, cmd_valid, get, busy, stall, set_we} = 6'h00;
    arm = 1'b1;
    cmd = '{CMD_NONE, 8'h00};
    stb = 8'h91;
    set_wd = 32'h0000_0000;
    n_fail = 0; total_checks = 0; n_trig = 0; n_bad = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    waitc(2);
    check("sre after reset", sre, SRE_RESET);
    check("esr after reset", esr, ESR_RESET);
    send(CMD_SRE, SRE_SRQ); waitc(2);
    check("sre load", sre, SRE_SRQ);
    ask(CMD_SRE_Q, d);
    check("sre query", d, SRE_SRQ);
    send(CMD_SRE, SRE_RESET); waitc(2);
    check("sre clear", sre, SRE_RESET);
    $display("test enable register done");
    ask(CMD_STB_Q, d);
    check("stb query", d, 8'h91);
    ask(CMD_STB_Q, d);
    check("stb query again", d, 8'h91);
    // stalled host: the answer must stand until taken
    stall <= 1'b1; g0 = got;
    send(CMD_STB_Q, 8'h00); waitc(5);
    check("resp held", {resp.valid, resp.data}, {1'b1, 8'h91});
    stall <= 1'b0; waitc(4);
    check("resp taken once", 32'(got - g0), 32'h1);
    $display("test status byte done");
    busy <= 1'b1; waitc(6);
    send(CMD_OPC, 8'h00); waitc(10);
    check("opc early", esr[OPC_BIT], 1'b0);
    check("stall behind opc", cmd_ready, 1'b0);
    busy <= 1'b0; waitc(10);
    check("opc done", esr[OPC_BIT], 1'b1);
    busy <= 1'b1; waitc(6); g0 = got;
    send(CMD_OPC_Q, 8'h00); waitc(10);
    check("opc query early", 32'(got - g0), 32'h0);
    busy <= 1'b0; waitc(12);
    check("opc query count", 32'(got - g0), 32'h1);
    check("opc query data", hdata, ASCII_ONE);
    $display("test completion done");
    // second pass overwrites every slot
    for (int p = 0; p < 2; p++)
      for (int n = 1; n <= SLOT_N; n++) begin
        @(posedge clk);
        set_wd <= 32'hA5A5_0000 + 32'(p * 256 + n);
        set_we <= 1'b1;
        @(posedge clk);
        set_we <= 1'b0;
        send(CMD_SAV, 8'(n)); waitc(2);
      end
    send(CMD_RST, 8'h00); waitc(3);
    check("reset settings", settings, SET_DEFAULT);
    for (int n = SLOT_N; n >= 1; n--) begin
      send(CMD_RCL, 8'(n)); waitc(3);
      check("recall slot", settings, 32'hA5A5_0100 + 32'(n));
    end
    b0 = n_bad; s0 = settings;
    send(CMD_SAV, 8'h00);
    send(CMD_RCL, 8'h06); waitc(3);
    check("bad slot pulses", 32'(n_bad - b0), 32'h2);
    check("bad slot ignored", settings, s0);
    rst_b <= 1'b0; waitc(2);
    rst_b <= 1'b1; waitc(2);
    send(CMD_RCL, 8'h02); waitc(3);
    check("slot kept over reset", settings, 32'hA5A5_0102);
    $display("test setups done");
    t0 = n_trig;
    send(CMD_TRG, 8'h00); waitc(3);
    check("trg with bus arm", 32'(n_trig - t0), 32'h1);
    arm <= 1'b0;
    send(CMD_TRG, 8'h00);
    get <= 1'b1; waitc(8);
    check("trg ignored", 32'(n_trig - t0), 32'h1);
    get <= 1'b0; arm <= 1'b1; waitc(6);
    get <= 1'b1; waitc(8);
    check("get with bus arm", 32'(n_trig - t0), 32'h2);
    get <= 1'b0;
    $display("test trigger done");
    test_done;
  end
endmodule
